// ### include/xb_pkg.sv
package xb_pkg;
   // ---------------------------------------------------------------
   // address map of the write-only ports
   // ---------------------------------------------------------------
   localparam logic [15:0] XB_LATCH_ADDR   = 16'hb000;
   localparam logic [15:0] XB_DAC_BASE     = 16'hb004;
   localparam int          XB_DAC_CHANNELS = 4;
   localparam logic [7:0]  XB_LATCH_RESET  = 8'h00;
   localparam logic [7:0]  XB_DAC_RESET    = 8'h00;
   // ---------------------------------------------------------------
   // pin fields and jumper encodings
   // ---------------------------------------------------------------
   localparam int          XB_BACKLIGHT_BIT = 6;
   localparam logic        XB_STYLE_SPLIT   = 1'b0;
   localparam logic        XB_STYLE_DIR     = 1'b1;
   // ---------------------------------------------------------------
   // bus cycle states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      XB_IDLE  = 2'b00,
      XB_ADDR  = 2'b01,
      XB_DATA  = 2'b11,
      XB_END   = 2'b10
   } xb_state_e;
endpackage

// ### include/xb_wr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface xb_wr_if;
   logic        wr_pulse;
   logic [15:0] addr;
   logic [7:0]  data;
   modport src (output wr_pulse, output addr, output data);
   modport dst (input wr_pulse, input addr, input data);
endinterface
`default_nettype wire

// ### tb/xb_card_model.sv
`timescale 1ns/10ps
`default_nettype none
module xb_card_model (
   input  wire logic       ref_clk,
   input  wire logic       hdr_reset,
   input  wire logic       wr_pin,
   input  wire logic       e_clk,
   input  wire logic       io_enable_pin,
   output logic [7:0]      wr_seen
);
   // a card counts data-phase writes; both strobe styles show wr low then
   always_ff @(posedge ref_clk) begin
      if (hdr_reset) begin
         wr_seen <= 8'h00;
      end else if (io_enable_pin && e_clk && !wr_pin) begin
         wr_seen <= wr_seen + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ### tb/xb_host_chk.sv
`timescale 1ns/10ps
`default_nettype none
module xb_host_chk (
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic        cpu_req,
   input wire logic        cpu_we,
   input wire logic        strobe_style_jumper,
   input wire logic        sel2_active_high,
   input wire logic        nmi_accept,
   input wire logic        aux_request_zero,
   input wire logic        e_clk,
   input wire logic        wr_pin,
   input wire logic        rd_n,
   input wire logic        second_io_select,
   input wire logic        io_enable_pin,
   input wire logic        pseudo_nmi_request_n,
   input wire logic        nmi_masked,
   input wire logic        irq_request_n,
   input wire logic [7:0]  driver_out,
   input wire logic [7:0]  driver_oe_n,
   input wire logic [31:0] dac_value
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // straps pass a synchroniser, so strobes are judged only once a strap has settled
   property p_levels; io_enable_pin && driver_out == 8'h00; endproperty
   a_levels: assert property (p_levels) else $error("enable low or driver sourcing");
   property p_wr_split; !strobe_style_jumper && !$past(strobe_style_jumper, 4) && $fell(wr_pin) |-> e_clk ##1 wr_pin; endproperty
   a_wr_split: assert property (p_wr_split) else $error("split write strobe shape");
   property p_wr_dir; strobe_style_jumper && $past(strobe_style_jumper, 4) && $fell(wr_pin)
      |-> !e_clk ##1 (e_clk && !wr_pin) ##1 wr_pin; endproperty
   a_wr_dir: assert property (p_wr_dir) else $error("direction line shape");
   property p_rd; !rd_n |-> e_clk && wr_pin; endproperty
   a_rd: assert property (p_rd) else $error("read strobe outside read data phase");
   property p_sel; strobe_style_jumper && $past(strobe_style_jumper, 4) && $past(sel2_active_high, 4) == sel2_active_high
      && second_io_select == sel2_active_high |-> e_clk; endproperty
   a_sel: assert property (p_sel) else $error("select active outside e phase");
   property p_nmi_acc; nmi_accept |=> nmi_masked ##1 pseudo_nmi_request_n; endproperty
   a_nmi_acc: assert property (p_nmi_acc) else $error("nmi not masked after accept");
   property p_irq; $stable(aux_request_zero) [*6] |-> irq_request_n == !aux_request_zero; endproperty
   a_irq: assert property (p_irq) else $error("request zero not inverted");
   property p_store; $changed({dac_value, driver_oe_n}) |-> ($past(cpu_req, 3) && $past(cpu_we, 3))
      || ($past(cpu_req, 4) && $past(cpu_we, 4)) || ($past(cpu_req, 5) && $past(cpu_we, 5)); endproperty
   a_store: assert property (p_store) else $error("port changed without write");
endmodule
bind xb_host xb_host_chk xb_host_chk_i (.*);
`default_nettype wire

// ### tb/xb_host_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module xb_host_tb_top;
   import xb_pkg::*;
   typedef struct packed {logic w; logic [15:0] a; logic [7:0] d; logic [39:0] q;} xb_row_s;
   logic ref_clk = 1'b0, nrst = 1'b0, cpu_req = 1'b0, cpu_we = 1'b0, cpu_sel2 = 1'b0;
   logic [15:0] cpu_addr = 16'h0000;
   logic [7:0] cpu_wdata = 8'h00;
   logic strobe_style_jumper = XB_STYLE_SPLIT, sel2_active_high = 1'b1, nmi_route_jumper = 1'b0;
   logic backlight_jumper_sw = 1'b0, backlight_jumper_on = 1'b0, port6_is_output = 1'b0, port6_level = 1'b0;
   logic nmi_unmask = 1'b0, nmi_accept = 1'b0, cpu_reset_req = 1'b0, low_voltage = 1'b0;
   logic aux_request_one = 1'b0, aux_request_zero = 1'b0;
   logic e_clk, wr_pin, rd_n, second_io_select, io_enable_pin, hdr_reset;
   logic pseudo_nmi_request_n, nmi_masked, irq_request_n, backlight_on;
   logic [7:0] driver_out, driver_oe_n, wr_seen;
   logic [31:0] dac_value;
   logic [3:0] nwr, nrd, nsel;
   int n_errors = 0, checks_done = 0;
   // reads and near-miss addresses must leave every port untouched
   xb_row_s rows [11] = '{
      '{1'b1, 16'hb004, 8'h11, 40'h00000011ff}, '{1'b1, 16'hb005, 8'h22, 40'h00002211ff},
      '{1'b1, 16'hb006, 8'h33, 40'h00332211ff}, '{1'b1, 16'hb007, 8'h44, 40'h44332211ff},
      '{1'b1, 16'hb000, 8'ha5, 40'h443322115a}, '{1'b0, 16'hb000, 8'h00, 40'h443322115a},
      '{1'b1, 16'hb008, 8'h77, 40'h443322115a}, '{1'b1, 16'hb001, 8'h77, 40'h443322115a},
      '{1'b1, 16'hb003, 8'h77, 40'h443322115a}, '{1'b1, 16'hb004, 8'h00, 40'h443322005a},
      '{1'b1, 16'hb000, 8'hff, 40'h4433220000}};
   // sw, on, port6 output, port6 level, lit
   logic [4:0] bl [5] = '{5'h17, 5'h14, 5'h12, 5'h09, 5'h06};
   xb_host xb_host_i (.*);
   xb_card_model xb_card_model_i (.ref_clk, .hdr_reset, .wr_pin, .e_clk, .io_enable_pin, .wr_seen);
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      if (n_errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // one bus cycle, then strobe cycles counted until the ports have settled
   task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      cpu_req <= 1'b1;
      cpu_we <= w;
      cpu_addr <= a;
      cpu_wdata <= d;
      @(posedge ref_clk);
      cpu_req <= 1'b0;
      {nwr, nrd, nsel} = 12'h000;
      repeat (7) begin
         @(negedge ref_clk);
         nwr += {3'h0, !wr_pin};
         nrd += {3'h0, !rd_n};
         nsel += {3'h0, second_io_select == sel2_active_high};
      end
   endtask
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_errors++;
      end_of_test;
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({hdr_reset, io_enable_pin, wr_pin, rd_n, nmi_masked, driver_oe_n, dac_value}, {5'h1f, 8'hff, 32'h0});
      @(posedge ref_clk);
      nrst <= 1'b1;
      for (int t = 0; t < 50 && hdr_reset !== 1'b0; t++) @(posedge ref_clk);
      foreach (rows[i]) begin
         cyc(rows[i].w, rows[i].a, rows[i].d);
         chk({dac_value, driver_oe_n}, rows[i].q);
         chk({nwr, nrd}, {3'h0, rows[i].w, 3'h0, !rows[i].w});
      end
      @(posedge ref_clk);
      strobe_style_jumper <= XB_STYLE_DIR;
      cpu_sel2 <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         @(posedge ref_clk);
         sel2_active_high <= p[0];
         repeat (6) @(posedge ref_clk);
         cyc(1'b1, 16'hb006, 8'h50 + 8'(p));
         chk({nwr, nrd, nsel, dac_value[23:16]}, {12'h201, 8'h50 + 8'(p)});
         cyc(1'b0, 16'hb006, 8'h00);
         chk({nwr, nrd, nsel}, 12'h011);
      end
      chk(wr_seen, 8'h0c);
      @(posedge ref_clk);
      cpu_reset_req <= 1'b1;
      @(posedge ref_clk);
      cpu_reset_req <= 1'b0;
      low_voltage <= 1'b1;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({hdr_reset, wr_seen}, 9'h100);
      @(posedge ref_clk);
      low_voltage <= 1'b0;
      nmi_route_jumper <= 1'b1;
      aux_request_one <= 1'b1;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(hdr_reset, 1'b0);
      // accept wins over unmask in the same cycle
      for (int k = 0; k < 4; k++) begin
         chk({nmi_masked, pseudo_nmi_request_n}, {2{!k[0]}});
         @(posedge ref_clk);
         nmi_unmask <= k != 3;
         nmi_accept <= k == 1;
         @(posedge ref_clk);
         nmi_unmask <= 1'b0;
         nmi_accept <= 1'b0;
         repeat (6) @(posedge ref_clk);
         @(negedge ref_clk);
      end
      for (int k = 0; k < 5; k++) begin
         @(posedge ref_clk);
         {backlight_jumper_sw, backlight_jumper_on, port6_is_output, port6_level} <= bl[k][4:1];
         aux_request_zero <= k[0];
         repeat (6) @(posedge ref_clk);
         @(negedge ref_clk);
         chk(backlight_on, bl[k][0]);
         chk(irq_request_n, !k[0]);
      end
      end_of_test;
   end
endmodule
`default_nettype wire

// ### verilog/xb_host.sv
`timescale 1ns/10ps
`default_nettype none
module xb_host
   import xb_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        cpu_req,
   input  wire logic        cpu_we,
   input  wire logic [15:0] cpu_addr,
   input  wire logic [7:0]  cpu_wdata,
   input  wire logic        cpu_sel2,
   input  wire logic        strobe_style_jumper,
   input  wire logic        sel2_active_high,
   input  wire logic        nmi_route_jumper,
   input  wire logic        backlight_jumper_sw,
   input  wire logic        backlight_jumper_on,
   input  wire logic        port6_is_output,
   input  wire logic        port6_level,
   input  wire logic        nmi_unmask,
   input  wire logic        nmi_accept,
   input  wire logic        cpu_reset_req,
   input  wire logic        low_voltage,
   input  wire logic        aux_request_one,
   input  wire logic        aux_request_zero,
   output logic             e_clk,
   output logic             wr_pin,
   output logic             rd_n,
   output logic             second_io_select,
   output logic             io_enable_pin,
   output logic             hdr_reset,
   output logic             pseudo_nmi_request_n,
   output logic             nmi_masked,
   output logic             irq_request_n,
   output logic             backlight_on,
   output logic [7:0]       driver_out,
   output logic [7:0]       driver_oe_n,
   output logic [31:0]      dac_value
);
   // ---------------------------------------------------------------
   // reset release and pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] rst_sync_q;
   wire        rst_n = rst_sync_q[1];
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   logic [5:0] pin_s1_q;
   logic [5:0] pin_s2_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= 6'h00;
         pin_s2_q <= 6'h00;
      end else begin
         pin_s1_q <= {low_voltage, aux_request_one, aux_request_zero,
                      nmi_route_jumper, backlight_jumper_sw, backlight_jumper_on};
         pin_s2_q <= pin_s1_q;
      end
   end
   wire lv_s    = pin_s2_q[5];
   wire req1_s  = pin_s2_q[4];
   wire req0_s  = pin_s2_q[3];
   wire route_s = pin_s2_q[2];
   wire bl_sw_s = pin_s2_q[1];
   wire bl_on_s = pin_s2_q[0];
   // style jumper and polarity are static straps; synchronised too
   logic [1:0] style_s1_q;
   logic [1:0] style_s2_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         style_s1_q <= 2'b00;
         style_s2_q <= 2'b00;
      end else begin
         style_s1_q <= {strobe_style_jumper, sel2_active_high};
         style_s2_q <= style_s1_q;
      end
   end
   wire style_dir = (style_s2_q[1] == XB_STYLE_DIR);
   wire sel2_pol  = style_s2_q[0];

   // ---------------------------------------------------------------
   // bus cycle sequencer; E is high in the data state only
   // ---------------------------------------------------------------
   xb_state_e   state_q;
   xb_state_e   state_d;
   logic        we_q;
   logic        sel2_q;
   logic [15:0] addr_q;
   logic [7:0]  wdata_q;
   logic        wr_pulse_q;

   always_comb begin
      unique case (state_q)
         XB_IDLE: state_d = cpu_req ? XB_ADDR : XB_IDLE;
         XB_ADDR: state_d = XB_DATA;
         XB_DATA: state_d = XB_END;
         XB_END:  state_d = XB_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= XB_IDLE;
         we_q    <= 1'b0;
         sel2_q  <= 1'b0;
         addr_q  <= 16'h0000;
         wdata_q <= 8'h00;
      end else begin
         state_q <= state_d;
         if (state_q == XB_IDLE && cpu_req) begin
            we_q    <= cpu_we;
            sel2_q  <= cpu_sel2;
            addr_q  <= cpu_addr;
            wdata_q <= cpu_wdata;
         end
      end
   end

   wire in_data   = (state_d == XB_DATA);
   wire in_cycle  = (state_d == XB_ADDR) || (state_d == XB_DATA);
   wire cyc_we    = (state_q == XB_IDLE) ? cpu_we : we_q;
   wire cyc_sel2  = (state_q == XB_IDLE) ? cpu_sel2 : sel2_q;
   // split style strobes only in data phase; direction line held through address and data phases
   wire wr_pin_d  = style_dir ? !(in_cycle && cyc_we)
                              : !(in_data && cyc_we);
   wire rd_n_d    = !(in_data && !cyc_we);
   // direction style: select only valid while E is high
   wire sel2_act  = cyc_sel2 && (style_dir ? in_data : in_cycle);
   wire sel2_d    = sel2_pol ? sel2_act : !sel2_act;
   // one write pulse per write cycle, at the data phase
   wire wr_pulse_d = (state_q == XB_ADDR) && we_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         e_clk            <= 1'b0;
         wr_pin           <= 1'b1;
         rd_n             <= 1'b1;
         second_io_select <= 1'b0;
         wr_pulse_q       <= 1'b0;
      end else begin
         e_clk            <= in_data;
         wr_pin           <= wr_pin_d;
         rd_n             <= rd_n_d;
         second_io_select <= sel2_d;
         wr_pulse_q       <= wr_pulse_d;
      end
   end

   // ---------------------------------------------------------------
   // write-only latch and converter channels
   // ---------------------------------------------------------------
   xb_wr_if wbus ();
   assign wbus.wr_pulse = wr_pulse_q;
   assign wbus.addr     = addr_q;
   assign wbus.data     = wdata_q;

   logic [7:0] latch_val;
   logic [7:0] dac_val [XB_DAC_CHANNELS];

   xb_wreg #(.ADDR(XB_LATCH_ADDR), .RESET(XB_LATCH_RESET)) u_latch (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .wr    (wbus),
      .value (latch_val)
   );

   for (genvar i = 0; i < XB_DAC_CHANNELS; i++) begin : g_dac
      xb_wreg #(.ADDR(XB_DAC_BASE + 16'(i)), .RESET(XB_DAC_RESET)) u_ch (
         .clk   (ref_clk),
         .rst_n (rst_n),
         .wr    (wbus),
         .value (dac_val[i])
      );
   end
   // reads of these locations return nothing; there is no read path

   // ---------------------------------------------------------------
   // drivers, backlight, enables
   // ---------------------------------------------------------------
   wire bl_d = bl_on_s || (bl_sw_s && port6_is_output && port6_level);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         driver_out   <= 8'h00;
         driver_oe_n  <= 8'hff;
         dac_value    <= 32'h0000_0000;
         backlight_on <= 1'b0;
      end else begin
         driver_out   <= 8'h00;
         driver_oe_n  <= ~latch_val;
         dac_value    <= {dac_val[3], dac_val[2], dac_val[1], dac_val[0]};
         backlight_on <= bl_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         io_enable_pin <= 1'b1;
      end else begin
         io_enable_pin <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // header reset and interrupt routing
   // ---------------------------------------------------------------
   // held high until reset release has cleared every source
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hdr_reset <= 1'b1;
      end else begin
         hdr_reset <= lv_s || cpu_reset_req;
      end
   end

   // nmi mask: set in reset and on acceptance; software may only clear
   wire nmi_mask_d = nmi_accept ? 1'b1 : (nmi_unmask ? 1'b0 : nmi_masked);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         nmi_masked <= 1'b1;
      end else begin
         nmi_masked <= nmi_mask_d;
      end
   end

   wire nmi_d = !(route_s && req1_s && !nmi_masked);
   wire irq_d = !req0_s;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pseudo_nmi_request_n <= 1'b1;
         irq_request_n        <= 1'b1;
      end else begin
         pseudo_nmi_request_n <= nmi_d;
         irq_request_n        <= irq_d;
      end
   end
endmodule
`default_nettype wire

// ### verilog/xb_wreg.sv
`timescale 1ns/10ps
`default_nettype none
module xb_wreg
   import xb_pkg::*;
#(
   parameter logic [15:0] ADDR  = 16'h0000,
   parameter logic [7:0]  RESET = 8'h00
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   xb_wr_if.dst            wr,
   output logic [7:0]      value
);
   wire hit = wr.wr_pulse && (wr.addr == ADDR);

   // holds until next write to the same address
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         value <= RESET;
      end else if (hit) begin
         value <= wr.data;
      end
   end
endmodule
`default_nettype wire
